/* design/dsc_serial_cmd.sv */
`timescale 1ns/1ps

// Function
// - Command is opcode word plus extension words
// - Decode opcode, direction, size, class, register fields
// - Direction one reads out, zero writes in
// - Size selects byte, word, long; 11 reserved
// - Addresses two words; immediates one or two
// - Multi-word values arrive most significant first
// - Class bit picks address or data register
// - Each exchange is one 17-bit full-duplex transfer
// - New command transfer returns previous low result
// - After command word: not-ready, or illegal code
// - Non-memory commands finish within eight clocks
// - Memory read starts after low address transfer
// - Transfers during access get not-ready
// - Long and register read results in two transfers after access completes; byte and word in one
// - Bus error returns error status instead
// - Memory commands steal bus cycles, no halt
// - Null and debug read run in parallel
// - Block commands continue from previous address
// - Null command has no effect
// - Resume restarts execution from current counter
// - Bit 16 is status; 0FFFF means done
// - Serial clock sampled as enable each edge
module dsc_serial_cmd
    import dsc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic host_serial_clock,
    input wire logic host_serial_in,
    output logic host_serial_out,
    input wire logic cpu_halted,
    output logic resume_pulse,
    output logic mem_req,
    output logic mem_we,
    output logic [1:0] mem_size,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic mem_err,
    output logic reg_req,
    output logic reg_we,
    output logic [1:0] reg_kind,
    output logic [15:0] reg_addr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    // ==========================================
    // Serial front end
    logic sclk_s1_r;
    logic sclk_s2_r;
    logic sclk_d_r;
    logic sin_s1_r;
    logic sin_s2_r;
    logic [4:0] bit_cnt_r;
    logic [16:0] rx_r;
    logic [16:0] tx_r;
    logic pkt_done_r;
    logic [15:0] pkt_word_r;
    logic [16:0] resp_r;
    logic sclk_rise;

    assign sclk_rise = sclk_s2_r & ~sclk_d_r;
    assign host_serial_out = tx_r[16];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_d_r <= 1'b0;
            sin_s1_r <= 1'b0;
            sin_s2_r <= 1'b0;
        end else if (clk_en) begin
            sclk_s1_r <= host_serial_clock;
            sclk_s2_r <= sclk_s1_r;
            sclk_d_r <= sclk_s2_r;
            sin_s1_r <= host_serial_in;
            sin_s2_r <= sin_s1_r;
        end
    end

    // Clock faster than half our rate would lose edges in the synchroniser
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bit_cnt_r <= 5'h00;
            rx_r <= 17'h00000;
            tx_r <= RESP_DONE;
            pkt_done_r <= 1'b0;
            pkt_word_r <= 16'h0000;
        end else if (clk_en) begin
            pkt_done_r <= 1'b0;
            if (sclk_rise) begin
                rx_r <= {rx_r[15:0], sin_s2_r};
                tx_r <= {tx_r[15:0], 1'b0};
                if (bit_cnt_r == 5'(PKT_BITS - 1)) begin
                    bit_cnt_r <= 5'h00;
                    pkt_done_r <= 1'b1;
                    pkt_word_r <= {rx_r[14:0], sin_s2_r}; // Host status bit ignored
                end else begin
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                end
            end else if (bit_cnt_r == 5'h00) begin
                tx_r <= resp_r;
            end
        end
    end

    // ==========================================
    // Command sequencer
    dsc_state_type state_r;
    logic [15:0] cmd_r;
    logic [63:0] ext_r;
    logic [2:0] ext_left_r;
    logic issued_r;
    logic [3:0] wait_cnt_r;
    logic [15:0] res_lo_r;
    logic [31:0] ptr_r;
    logic after_read_r;
    logic after_write_r;
    logic res_armed_r;
    logic [31:0] control_r;

    logic [5:0] opc;
    logic [1:0] size;
    logic dir;
    logic [2:0] ext_need;
    logic illegal;
    logic [5:0] c_opc;
    logic [1:0] c_size;
    logic c_dir;
    logic [31:0] step;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic needs_halt;

    assign opc = pkt_word_r[OPC_MSB:OPC_LSB];
    assign dir = pkt_word_r[DIR_BIT];
    assign size = pkt_word_r[SIZE_MSB:SIZE_LSB];
    assign c_opc = cmd_r[OPC_MSB:OPC_LSB];
    assign c_dir = cmd_r[DIR_BIT];
    assign c_size = cmd_r[SIZE_MSB:SIZE_LSB];

    always_comb begin
        ext_need = 3'h0;
        illegal = 1'b0;
        case (opc)
            OPC_NULL, OPC_RESUME: ext_need = 3'h0;
            OPC_MEM: begin
                // Two address words, then one or two data words on write
                if (dir) begin
                    ext_need = 3'h2;
                end else begin
                    ext_need = (size == SIZE_LONG) ? 3'h4 : 3'h3;
                end
                illegal = (size == 2'h3);
            end
            OPC_BLOCK: begin
                ext_need = (dir || size != SIZE_LONG) ? (dir ? 3'h0 : 3'h1) : 3'h2;
                illegal = (size == 2'h3) || (dir ? !after_read_r : !after_write_r);
            end
            OPC_CPU_REG: ext_need = dir ? 3'h0 : 3'h2;
            OPC_CTRL_REG: ext_need = dir ? 3'h2 : 3'h4;
            OPC_DEBUG_REG: ext_need = dir ? 3'h0 : 3'h2;
            default: illegal = 1'b1;
        endcase
        if (!control_r[CTRL_ENABLE_BIT]) begin
            illegal = 1'b1;
        end
    end

    always_comb begin
        case (c_size)
            SIZE_BYTE: step = 32'h0000_0001;
            SIZE_WORD: step = 32'h0000_0002;
            default: step = 32'h0000_0004;
        endcase
        needs_halt = (c_opc == OPC_CPU_REG) || (c_opc == OPC_RESUME) ||
                     (c_opc == OPC_CTRL_REG) || (c_opc == OPC_DEBUG_REG && !c_dir);
        if (c_opc == OPC_BLOCK) begin
            wr_addr = ptr_r;
        end else if (c_size == SIZE_LONG) begin
            wr_addr = ext_r[63:32];
        end else begin
            wr_addr = ext_r[47:16];
        end
        wr_data = (c_size == SIZE_LONG) ? ext_r[31:0] : {16'h0000, ext_r[15:0]};
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ST_CMD;
            cmd_r <= 16'h0000;
            ext_r <= 64'h0;
            ext_left_r <= 3'h0;
            issued_r <= 1'b0;
            wait_cnt_r <= 4'h0;
            res_lo_r <= 16'h0000;
            resp_r <= RESP_DONE;
            ptr_r <= 32'h0;
            after_read_r <= 1'b0;
            after_write_r <= 1'b0;
            res_armed_r <= 1'b0;
            resume_pulse <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_size <= SIZE_BYTE;
            mem_addr <= 32'h0;
            mem_wdata <= 32'h0;
            reg_req <= 1'b0;
            reg_we <= 1'b0;
            reg_kind <= KIND_CPU;
            reg_addr <= 16'h0000;
            reg_wdata <= 32'h0;
        end else if (clk_en) begin
            resume_pulse <= 1'b0;
            case (state_r)
                ST_CMD: begin
                    if (pkt_done_r) begin
                        cmd_r <= pkt_word_r;
                        if (illegal) begin
                            resp_r <= RESP_ILLEGAL;
                        end else begin
                            resp_r <= RESP_NOT_READY;
                            ext_left_r <= ext_need;
                            issued_r <= 1'b0;
                            state_r <= (ext_need == 3'h0) ? ST_EXEC : ST_EXT;
                            if (opc != OPC_NULL) begin
                                after_read_r <= 1'b0;
                                after_write_r <= 1'b0;
                            end
                        end
                    end
                end
                ST_EXT: begin
                    if (pkt_done_r) begin
                        ext_r <= {ext_r[47:0], pkt_word_r};
                        resp_r <= RESP_NOT_READY;
                        ext_left_r <= ext_left_r - 3'h1;
                        if (ext_left_r == 3'h1) begin
                            state_r <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    resp_r <= RESP_NOT_READY;
                    res_armed_r <= 1'b0;
                    if (!issued_r) begin
                        issued_r <= 1'b1;
                        wait_cnt_r <= 4'h0;
                        if (needs_halt && !cpu_halted) begin
                            resp_r <= RESP_BUS_ERROR;
                            state_r <= ST_CMD;
                        end else if (c_opc == OPC_NULL) begin
                            resp_r <= RESP_DONE;
                            state_r <= ST_CMD;
                        end else if (c_opc == OPC_RESUME) begin
                            resume_pulse <= 1'b1;
                            resp_r <= RESP_DONE;
                            state_r <= ST_CMD;
                        end else if (c_opc == OPC_MEM || c_opc == OPC_BLOCK) begin
                            mem_req <= 1'b1;
                            mem_we <= !c_dir;
                            mem_size <= c_size;
                            if (c_dir) begin
                                mem_addr <= (c_opc == OPC_BLOCK) ? ptr_r : ext_r[31:0];
                            end else begin
                                mem_addr <= wr_addr;
                            end
                            mem_wdata <= (c_opc == OPC_BLOCK) ?
                                ((c_size == SIZE_LONG) ? ext_r[31:0] : {16'h0000, ext_r[15:0]}) :
                                wr_data;
                        end else begin
                            reg_req <= 1'b1;
                            reg_we <= !c_dir;
                            reg_wdata <= ext_r[31:0];
                            case (c_opc)
                                OPC_CPU_REG: begin
                                    reg_kind <= KIND_CPU;
                                    reg_addr <= {12'h000, cmd_r[CLASS_BIT], cmd_r[REGNUM_MSB:0]};
                                end
                                OPC_CTRL_REG: begin
                                    reg_kind <= KIND_CTRL;
                                    reg_addr <= c_dir ? ext_r[15:0] : ext_r[47:32];
                                end
                                default: begin
                                    reg_kind <= KIND_DEBUG;
                                    reg_addr <= {12'h000, cmd_r[3:0]};
                                end
                            endcase
                        end
                    end else if (mem_req && (mem_ack || mem_err)) begin
                        mem_req <= 1'b0;
                        ptr_r <= mem_addr + step;
                        after_read_r <= c_dir;
                        after_write_r <= !c_dir;
                        state_r <= ST_CMD;
                        if (mem_err) begin
                            resp_r <= RESP_BUS_ERROR;
                        end else if (!c_dir) begin
                            resp_r <= RESP_DONE;
                        end else if (c_size == SIZE_LONG) begin
                            resp_r <= {1'b0, mem_rdata[31:16]};
                            res_lo_r <= mem_rdata[15:0];
                            state_r <= ST_RES;
                        end else if (c_size == SIZE_BYTE) begin
                            resp_r <= {9'h000, mem_rdata[7:0]};
                        end else begin
                            resp_r <= {1'b0, mem_rdata[15:0]};
                        end
                    end else if (reg_req) begin
                        wait_cnt_r <= wait_cnt_r + 4'h1;
                        if (reg_ack) begin
                            reg_req <= 1'b0;
                            state_r <= ST_CMD;
                            if (reg_we) begin
                                resp_r <= RESP_DONE;
                            end else begin
                                resp_r <= {1'b0, reg_rdata[31:16]};
                                res_lo_r <= reg_rdata[15:0];
                                state_r <= ST_RES;
                            end
                        end else if (wait_cnt_r == 4'(RECOVERY_CYCLES - 2)) begin
                            // Hung register port must not stall the link forever
                            reg_req <= 1'b0;
                            resp_r <= RESP_BUS_ERROR;
                            state_r <= ST_CMD;
                        end
                    end
                end
                ST_RES: begin
                    // A transfer begun before the result landed carried not-ready
                    if (bit_cnt_r == 5'h00 && !sclk_rise) begin
                        res_armed_r <= 1'b1;
                    end
                    if (pkt_done_r && res_armed_r) begin
                        resp_r <= {1'b0, res_lo_r};
                        state_r <= ST_CMD;
                    end
                end
                default: state_r <= ST_CMD;
            endcase
        end
    end

    // ==========================================
    // Wishbone slave
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            control_r <= CONTROL_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (clk_en) begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                if (wb_we_i && wb_adr_i == ADDR_CONTROL && wb_sel_i[0]) begin
                    control_r[CTRL_ENABLE_BIT] <= wb_dat_i[CTRL_ENABLE_BIT];
                end
                case (wb_adr_i)
                    ADDR_CONTROL: wb_dat_o <= control_r;
                    ADDR_STATUS: wb_dat_o <= {18'h00000, cmd_r[OPC_MSB:OPC_LSB], 4'h0,
                                              after_write_r, after_read_r, state_r};
                    ADDR_POINTER: wb_dat_o <= ptr_r;
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

endmodule

/* include/dsc_pkg.sv */
package dsc_pkg;

    // ==========================================
    // Packet and command word layout
    localparam int PKT_BITS = 17;
    localparam int WORD_BITS = 16;
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 10;
    localparam int DIR_BIT = 8;
    localparam int SIZE_MSB = 7;
    localparam int SIZE_LSB = 6;
    localparam int CLASS_BIT = 3;
    localparam int REGNUM_MSB = 2;

    // ==========================================
    // Operation codes (bits 15:10)
    localparam logic [5:0] OPC_NULL = 6'h00;
    localparam logic [5:0] OPC_RESUME = 6'h03;
    localparam logic [5:0] OPC_MEM = 6'h06;
    localparam logic [5:0] OPC_BLOCK = 6'h07;
    localparam logic [5:0] OPC_CPU_REG = 6'h08;
    localparam logic [5:0] OPC_CTRL_REG = 6'h0a;
    localparam logic [5:0] OPC_DEBUG_REG = 6'h0b;

    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    // ==========================================
    // Response packets
    localparam logic [16:0] RESP_DONE = 17'h0ffff;
    localparam logic [16:0] RESP_NOT_READY = 17'h10000;
    localparam logic [16:0] RESP_BUS_ERROR = 17'h10001;
    localparam logic [16:0] RESP_ILLEGAL = 17'h1ffff;

    // ==========================================
    // Register access kinds
    localparam logic [1:0] KIND_CPU = 2'h0;
    localparam logic [1:0] KIND_CTRL = 2'h1;
    localparam logic [1:0] KIND_DEBUG = 2'h2;

    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int RECOVERY_CYCLES = 8;

    // ==========================================
    // Wishbone register map
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_POINTER = 4'h8;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;
    localparam int CTRL_ENABLE_BIT = 0;

    typedef enum logic [1:0] {
        ST_CMD = 2'b00,
        ST_EXT = 2'b01,
        ST_EXEC = 2'b11,
        ST_RES = 2'b10
    } dsc_state_type;

endpackage

/* testbench/dsc_serial_cmd_asserts.sv */
`timescale 1ns/1ps

// ==========================================
// Port checks
module dsc_serial_cmd_asserts
    import dsc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic host_serial_out,
    input wire logic cpu_halted,
    input wire logic resume_pulse,
    input wire logic mem_req,
    input wire logic [1:0] mem_size,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic reg_req,
    input wire logic [1:0] reg_kind,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Reset itself is the antecedent, so it must not disable this one
    property p_rst_quiet;
        disable iff (1'b0)
        sys_rst |=> !host_serial_out && !mem_req && !resume_pulse && !wb_ack_o;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
    property p_mem_hold;
        mem_req && !mem_ack && !mem_err |=> mem_req && $stable(mem_addr);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("memory request moved");
    property p_mem_end;
        mem_req && (mem_ack || mem_err) |=> !mem_req;
    endproperty
    a_mem_end: assert property (p_mem_end) else $error("memory request kept");
    property p_mem_size;
        mem_req |-> mem_size != 2'h3;
    endproperty
    a_mem_size: assert property (p_mem_size) else $error("reserved size used");
    property p_resume_halt;
        resume_pulse |-> cpu_halted;
    endproperty
    a_resume_halt: assert property (p_resume_halt) else $error("resume while running");
    property p_resume_pulse;
        resume_pulse |=> !resume_pulse;
    endproperty
    a_resume_pulse: assert property (p_resume_pulse) else $error("resume too long");
    property p_reg_halt;
        $rose(reg_req) && reg_kind == KIND_CPU |-> cpu_halted;
    endproperty
    a_reg_halt: assert property (p_reg_halt) else $error("register access running");
    property p_reg_bound;
        $rose(reg_req) |-> ##[1:9] !reg_req;
    endproperty
    a_reg_bound: assert property (p_reg_bound) else $error("register access too long");
    property p_wb_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("bus answer late");
    property p_wb_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_wb_pulse: assert property (p_wb_pulse) else $error("bus answer held");
    property p_wb_hole;
        wb_ack_o && wb_adr_i == 4'hc |-> wb_dat_o == 32'h0;
    endproperty
    a_wb_hole: assert property (p_wb_hole) else $error("unmapped read not zero");
    c_mem: cover property ($rose(mem_req));
    c_err: cover property (mem_req && mem_err);
    c_reg: cover property ($rose(reg_req));
    c_resume: cover property (resume_pulse);
endmodule

bind dsc_serial_cmd dsc_serial_cmd_asserts u_chk (.*);

/* testbench/dsc_host_model.sv */
`timescale 1ns/1ps

// ==========================================
// Serial debug host
module dsc_host_model (
    input wire logic clk,
    output logic sclk,
    output logic sdi,
    input wire logic sdo
);
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // Clock stands low between packets, so the device sees no stray edges
    task automatic xfer(input logic [15:0] w, output logic [16:0] rx);
        logic [16:0] p;
        p = {1'b0, w};
        for (int i = 16; i >= 0; i--) begin
            @(posedge clk);
            sdi <= p[i];
            repeat (15) @(posedge clk);
            rx[i] = sdo;
            sclk <= 1'b1;
            repeat (16) @(posedge clk);
            sclk <= 1'b0;
        end
        sdi <= ~sdi;
        repeat (24) @(posedge clk);
    endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps

// ==========================================
// Bench
module testbench
    import dsc_pkg::*;
;
    typedef struct packed {logic h; logic [15:0] pk; logic [16:0] ex;} dsc_row_type;
    logic clk, sys_rst, sclk, sdi, sdo, cpu_halted, resume_pulse, mem_req, mem_we;
    logic mem_ack, mem_err, reg_req, reg_we, reg_ack, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic err_mode;
    logic [1:0] mem_size, reg_kind, r_kind;
    logic [3:0] wb_adr_i;
    logic [15:0] reg_addr, r_addr;
    logic [31:0] mem_addr, mem_wdata, reg_wdata, wb_dat_i, wb_dat_o, m_addr, m_wd, r_wd, q;
    int error_cnt = 0, n_compared = 0, cyc_cnt = 0, mdly = 2, mcnt = 0;
    int m_n = 0, r_n = 0, rs_n = 0;
    // Each row is one transfer: halt level, host word, response due
    dsc_row_type rows [23] = '{
        '{1'b0,16'h1980,17'h0ffff}, '{1'b0,16'h0000,17'h10000}, '{1'b0,16'h1000,17'h10000},
        '{1'b0,16'h0000,17'h01234}, '{1'b0,16'h1840,17'h05678}, '{1'b0,16'h0000,17'h10000},
        '{1'b0,16'h2000,17'h10000}, '{1'b0,16'h00cd,17'h10000}, '{1'b0,16'h0000,17'h0ffff},
        '{1'b0,16'h1c40,17'h0ffff}, '{1'b0,16'h00ef,17'h10000}, '{1'b0,16'h18c0,17'h0ffff},
        '{1'b0,16'h0000,17'h1ffff}, '{1'b1,16'h200b,17'h0ffff}, '{1'b1,16'h1111,17'h10000},
        '{1'b1,16'h2222,17'h10000}, '{1'b1,16'h1c40,17'h0ffff}, '{1'b1,16'h0c00,17'h1ffff},
        '{1'b0,16'h2003,17'h0ffff}, '{1'b0,16'h1111,17'h10000}, '{1'b0,16'h2222,17'h10000},
        '{1'b0,16'h0000,17'h10001}, '{1'b0,16'h0000,17'h0ffff}};

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    dsc_serial_cmd dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
        .host_serial_clock(sclk), .host_serial_in(sdi), .host_serial_out(sdo),
        .cpu_halted(cpu_halted), .resume_pulse(resume_pulse), .mem_req(mem_req),
        .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(32'h1234_5678), .mem_ack(mem_ack), .mem_err(mem_err), .reg_req(reg_req),
        .reg_we(reg_we), .reg_kind(reg_kind), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(32'h9abc_def0), .reg_ack(reg_ack), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    dsc_host_model host (.clk(clk), .sclk(sclk), .sdi(sdi), .sdo(sdo));

    // Processor side: memory answers mdly+1 cycles after the request, registers one after
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        mem_err <= 1'b0;
        reg_ack <= reg_req && !reg_ack;
        if (mem_req && !mem_ack && !mem_err) begin
            mcnt <= mcnt + 1;
            if (mcnt >= mdly) begin
                mem_ack <= !err_mode;
                mem_err <= err_mode;
                mcnt <= 0;
            end
        end
        if (mem_req && (mem_ack || mem_err)) begin
            m_n <= m_n + 1;
            m_addr <= mem_addr;
            m_wd <= mem_wdata;
        end
        if (reg_req && reg_ack) begin
            r_n <= r_n + 1;
            r_addr <= reg_addr;
            r_wd <= reg_wdata;
            r_kind <= reg_kind;
        end
        if (resume_pulse) begin
            rs_n <= rs_n + 1;
        end
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 60000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tx(input logic [15:0] w, input logic [16:0] ex, input bit ck);
        logic [16:0] r;
        host.xfer(w, r);
        if (ck) begin
            chk("serial response", {15'h0, r}, {15'h0, ex});
        end
    endtask

    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    task final_report();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        cpu_halted = 1'b0;
        err_mode = 1'b0;
        mem_ack = 1'b0;
        mem_err = 1'b0;
        reg_ack = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            cpu_halted <= rows[i].h;
            tx(rows[i].pk, rows[i].ex, 1);
        end
        chk("mem count", m_n, 32'h3);
        chk("mem addr", m_addr, 32'h2002);
        chk("mem data", m_wd, 32'h00ef);
        chk("reg count", r_n, 32'h1);
        chk("reg addr", {16'h0, r_addr}, 32'h000b);
        chk("reg data", r_wd, 32'h1111_2222);
        chk("reg kind", {30'h0, r_kind}, {30'h0, KIND_CPU});
        chk("resume count", rs_n, 32'h1);
        $display("test table done");
        mdly = 300;
        tx(16'h1980, 17'h0ffff, 1);
        tx(16'h0000, 17'h10000, 0);
        tx(16'h3000, 17'h10000, 0);
        tx(16'h0000, 17'h10000, 1);
        tx(16'h0000, 17'h01234, 1);
        tx(16'h0000, 17'h05678, 1);
        mdly = 2;
        tx(16'h1d80, 17'h0ffff, 1);
        chk("block addr", m_addr, 32'h3004);
        tx(16'h0000, 17'h01234, 1);
        tx(16'h1d40, 17'h05678, 1);
        tx(16'h1d00, 17'h05678, 1);
        tx(16'h0000, 17'h00078, 1);
        chk("byte block addr", m_addr, 32'h300a);
        $display("test slow and block done");
        err_mode = 1'b1;
        tx(16'h1800, 17'h0, 0);
        tx(16'h0000, 17'h0, 0);
        tx(16'h4000, 17'h0, 0);
        tx(16'h0011, 17'h0, 0);
        tx(16'h0000, 17'h10001, 1);
        err_mode = 1'b0;
        tx(16'h0000, 17'h0ffff, 1);
        $display("test bus error done");
        wb(1'b0, ADDR_CONTROL, 32'h0);
        chk("control reset", q, CONTROL_RESET);
        wb(1'b1, ADDR_CONTROL, 32'h0);
        wb(1'b1, 4'hc, 32'hffff_ffff);
        wb(1'b0, 4'hc, 32'h0);
        chk("unmapped read", q, 32'h0);
        tx(16'h0000, 17'h0ffff, 0);
        tx(16'h0000, 17'h1ffff, 1);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("serial out in reset", {31'h0, sdo}, 32'h0);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        tx(16'h0000, 17'h0ffff, 1);
        wb(1'b0, ADDR_CONTROL, 32'h0);
        chk("control after reset", q, CONTROL_RESET);
        $display("test bus and reset done");
        final_report();
    end
endmodule
